// *** cfu_cmp_properties.sv ***
`timescale 1ns/1ps
module cfu_cmp_properties (
  input wire        core_clk_i,           // clock
  input wire        rstn_i,               // reset
  input wire        exec_i,               // strobe
  input wire [9:0]  opcode_i,             // code
  input wire [15:0] first_operand_i,      // a low
  input wire [15:0] first_operand_hi_i,   // a high
  input wire [15:0] second_operand_i,     // b low
  input wire [15:0] second_operand_hi_i,  // b high
  input wire [5:0]  mask_i,               // mask
  input wire        exec_cond_o,          // result
  input wire        cond_valid_o,         // result pulse
  input wire        skip_rung_o,          // skip
  input wire        error_flag_o,         // error
  input wire        greater_flag_o,       // gt
  input wire        greater_equal_flag_o, // ge
  input wire        equal_flag_o,         // eq
  input wire        not_equal_flag_o,     // ne
  input wire        less_flag_o,          // lt
  input wire        less_equal_flag_o     // le
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire tm = exec_i && opcode_i >= 10'd341 && opcode_i <= 10'd346;
  wire pc = exec_i && (opcode_i == 10'd20 || opcode_i == 10'd60);
  a_ge_join: assert property (greater_equal_flag_o == (greater_flag_o | equal_flag_o))
    else $error("ge flag differs from gt or eq");
  a_le_join: assert property (less_equal_flag_o == (less_flag_o | equal_flag_o))
    else $error("le flag differs from lt or eq");
  a_ne_join: assert property (not_equal_flag_o == (greater_flag_o | less_flag_o))
    else $error("ne flag differs from gt or lt");
  a_eq_single: assert property (exec_i && opcode_i == 10'd300 |=>
    equal_flag_o == ($past(first_operand_i) == $past(second_operand_i)))
    else $error("equal flag wrong after single equal");
  a_lt_single: assert property (exec_i && opcode_i == 10'd310 |=>
    less_flag_o == ($past(first_operand_i) < $past(second_operand_i)))
    else $error("less flag wrong after single less");
  a_double_gt: assert property (exec_i && opcode_i == 10'd60 |=> greater_flag_o ==
    ({$past(first_operand_hi_i), $past(first_operand_i)} >
     {$past(second_operand_hi_i), $past(second_operand_i)}))
    else $error("greater flag wrong after double compare");
  a_plain_quiet: assert property (pc |=>
    !cond_valid_o && $stable(exec_cond_o) && $stable(error_flag_o))
    else $error("plain compare touched condition or error");
  a_mask_error: assert property (tm && mask_i == 6'h3f |=> error_flag_o && !exec_cond_o)
    else $error("fully masked time compare not refused");
  a_time_ok: assert property (tm && mask_i != 6'h3f |=> cond_valid_o && !error_flag_o)
    else $error("time compare gave no result");
  a_skip_off: assert property (skip_rung_o |-> !exec_cond_o)
    else $error("skip with condition on");
  cover property (skip_rung_o);
  cover property (tm ##1 error_flag_o);
  cover property (pc ##1 greater_flag_o);
endmodule // cfu_cmp_properties
bind cfu_compare_flag_unit cfu_cmp_properties u_chk (.*);

// *** cfu_compare_flag_unit.v ***
`timescale 1ns/1ps
`include "cfu_consts.vh"
// How it works
// - input comparison with no options compares one-word unsigned values
// - codes 300-303 equal, 305-308 not equal, variants in fixed order
// - codes 310-313 less, 315-318 less-or-equal
// - codes 320-323 greater, 325-328 greater-or-equal
// - unsigned variants order by magnitude, signed variants by two's complement
// - result acts as load, and-series or or-parallel contact
// - false and-series comparison turns condition off and skips the rung
// - time comparisons 341-346 in order equal to greater-or-equal
// - control bits 0-5 mask second through year
// - all six masked: no compare, result false (or-parallel passes the incoming condition), error set; else error clear
// - time operand is three words of packed bcd bytes
// - years 98,99 rank before 00-97
// - time comparison with any field unmasked updates all six relation flags
// - time fields are compared as separate bytes
// - clockless model reads calendar as 01-01-01 01:01:01
// - codes 020 and 060 only update flags, no condition
// - double operand: low word at given address, high word next
// - input comparison sets each relation flag from the operands
// - plain compare keeps the error flag, sets relation flags
module cfu_compare_flag_unit #(
  parameter HAS_CLOCK = 1            // 0 models the variant without real-time clock
) (
  input  wire        core_clk_i,          // cpu clock
  input  wire        rstn_i,              // async reset, active low
  input  wire        exec_i,              // one-cycle instruction strobe
  input  wire [9:0]  opcode_i,            // function code
  input  wire [1:0]  form_i,              // contact form
  input  wire        cond_i,              // incoming execution condition
  input  wire [15:0] first_operand_i,     // first operand, low word
  input  wire [15:0] first_operand_hi_i,  // first operand, next word
  input  wire [15:0] second_operand_i,    // second operand, low word
  input  wire [15:0] second_operand_hi_i, // second operand, next word
  input  wire [47:0] first_time_i,        // present time words 0..2
  input  wire [47:0] second_time_i,       // comparison time words 0..2
  input  wire        use_calendar_i,      // take present time from calendar
  input  wire [5:0]  mask_i,              // control word bits 5:0
  input  wire        cal_wr_i,            // calendar write strobe
  input  wire [1:0]  cal_sel_i,           // calendar word 0..2
  input  wire [15:0] cal_wdata_i,         // calendar write data
  output wire [15:0] calendar_second_minute_o, // calendar word 0
  output wire [15:0] calendar_hour_day_o,      // calendar word 1
  output wire [15:0] calendar_month_year_o,    // calendar word 2
  output reg         exec_cond_o,         // resulting execution condition
  output reg         cond_valid_o,        // exec_cond_o updated this cycle
  output reg         skip_rung_o,         // rest of rung is skipped
  output reg         error_flag_o,        // error flag
  output reg         greater_flag_o,      // greater flag
  output reg         greater_equal_flag_o,// greater-or-equal flag
  output reg         equal_flag_o,        // equal flag
  output reg         not_equal_flag_o,    // not-equal flag
  output reg         less_flag_o,         // less flag
  output reg         less_equal_flag_o    // less-or-equal flag
);
  wire       is_input;
  wire [2:0] rel;
  wire       dbl;
  wire       sgn;
  wire       t_gt;
  wire       t_lt;
  reg  [15:0] cal0_reg;
  reg  [15:0] cal1_reg;
  reg  [15:0] cal2_reg;
  wire [47:0] present_time;
  reg  [32:0] a_ext;
  reg  [32:0] b_ext;
  reg         gt;
  reg         lt;
  reg         eq;
  reg         truth;
  reg         is_time;
  reg         is_plain;
  reg  [2:0]  trel;
  reg  [9:0]  tdiff;
  reg         all_masked;

  cfu_rel_decode u_dec (
    .opcode_i   (opcode_i),
    .is_input_o (is_input),
    .rel_o      (rel),
    .double_o   (dbl),
    .signed_o   (sgn)
  );

  // calendar words, fixed when the clock is absent
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal0_reg <= `CFU_FIXED_CAL;
      cal1_reg <= `CFU_FIXED_CAL;
      cal2_reg <= `CFU_FIXED_CAL;
    end else if (cal_wr_i && HAS_CLOCK != 0) begin
      case (cal_sel_i)
        2'd0: cal0_reg <= cal_wdata_i;
        2'd1: cal1_reg <= cal_wdata_i;
        2'd2: cal2_reg <= cal_wdata_i;
        default: cal0_reg <= cal0_reg;
      endcase
    end
  end
  assign calendar_second_minute_o = HAS_CLOCK != 0 ? cal0_reg : `CFU_FIXED_CAL;
  assign calendar_hour_day_o      = HAS_CLOCK != 0 ? cal1_reg : `CFU_FIXED_CAL;
  assign calendar_month_year_o    = HAS_CLOCK != 0 ? cal2_reg : `CFU_FIXED_CAL;
  assign present_time = use_calendar_i ?
    {calendar_month_year_o, calendar_hour_day_o, calendar_second_minute_o} : first_time_i;

  cfu_time_cmp u_time (
    .first_time_i  (present_time),
    .second_time_i (second_time_i),
    .mask_i        (mask_i),
    .greater_o     (t_gt),
    .less_o        (t_lt)
  );

  always @* begin
    is_time    = opcode_i >= `CFU_OP_TEQ && opcode_i <= `CFU_OP_TGE;
    is_plain   = opcode_i == `CFU_OP_CMP || opcode_i == `CFU_OP_PLAIN_COMPARE_DOUBLE;
    tdiff      = opcode_i - `CFU_OP_TEQ;
    trel       = tdiff[2:0];
    all_masked = mask_i == `CFU_MASK_ALL;
    // high word only joins in for double length; the sign bit extends for signed
    if (dbl || opcode_i == `CFU_OP_PLAIN_COMPARE_DOUBLE) begin
      a_ext = {sgn & first_operand_hi_i[15], first_operand_hi_i, first_operand_i};
      b_ext = {sgn & second_operand_hi_i[15], second_operand_hi_i, second_operand_i};
    end else begin
      a_ext = {{17{sgn & first_operand_i[15]}}, first_operand_i};
      b_ext = {{17{sgn & second_operand_i[15]}}, second_operand_i};
    end
    // flip the top bit so signed order becomes unsigned order
    if (sgn) begin
      a_ext[32] = ~a_ext[31];
      b_ext[32] = ~b_ext[31];
    end else begin
      a_ext[32] = 1'b0;
      b_ext[32] = 1'b0;
    end
    gt = is_time ? t_gt : (a_ext > b_ext);
    lt = is_time ? t_lt : (a_ext < b_ext);
    eq = !gt && !lt;
    case (is_time ? trel : rel)
      `CFU_REL_EQ: truth = eq;
      `CFU_REL_NE: truth = !eq;
      `CFU_REL_LT: truth = lt;
      `CFU_REL_LE: truth = !gt;
      `CFU_REL_GT: truth = gt;
      `CFU_REL_GE: truth = !lt;
      default:     truth = 1'b0;
    endcase
    if (is_time && all_masked)
      truth = 1'b0;
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exec_cond_o          <= 1'b0;
      cond_valid_o         <= 1'b0;
      skip_rung_o          <= 1'b0;
      error_flag_o         <= 1'b0;
      greater_flag_o       <= 1'b0;
      greater_equal_flag_o <= 1'b0;
      equal_flag_o         <= 1'b0;
      not_equal_flag_o     <= 1'b0;
      less_flag_o          <= 1'b0;
      less_equal_flag_o    <= 1'b0;
    end else begin
      cond_valid_o <= 1'b0;
      skip_rung_o  <= 1'b0;
      if (exec_i && (is_input || is_time || is_plain)) begin
        if (!is_plain) begin
          cond_valid_o <= 1'b1;
          case (form_i)
            `CFU_FORM_LOAD: exec_cond_o <= truth;
            `CFU_FORM_AND: begin
              exec_cond_o <= cond_i & truth;
              skip_rung_o <= !truth;
            end
            `CFU_FORM_OR:   exec_cond_o <= cond_i | truth;
            default:        exec_cond_o <= truth;
          endcase
        end
        if (is_time)
          error_flag_o <= all_masked;
        else if (is_input)
          error_flag_o <= 1'b0;
        // plain compare leaves the error flag alone
        if (!(is_time && all_masked)) begin
          greater_flag_o       <= gt;
          greater_equal_flag_o <= !lt;
          equal_flag_o         <= eq;
          not_equal_flag_o     <= !eq;
          less_flag_o          <= lt;
          less_equal_flag_o    <= !gt;
        end
      end
    end
  end
endmodule // cfu_compare_flag_unit

// *** cfu_consts.vh ***
`ifndef CFU_CONSTS_VH
`define CFU_CONSTS_VH
// opcodes, 10-bit field holding the decimal function code
`define CFU_OP_EQ_BASE   10'd300
`define CFU_OP_NE_BASE   10'd305
`define CFU_OP_LT_BASE   10'd310
`define CFU_OP_LE_BASE   10'd315
`define CFU_OP_GT_BASE   10'd320
`define CFU_OP_GE_BASE   10'd325
`define CFU_OP_TEQ       10'd341
`define CFU_OP_TGE       10'd346
`define CFU_OP_CMP       10'd20
`define CFU_OP_PLAIN_COMPARE_DOUBLE      10'd60
// variant offset within a family
`define CFU_VAR_DOUBLE   2'd1
`define CFU_VAR_SIGNED   2'd2
`define CFU_VAR_SDOUBLE  2'd3
// relation codes
`define CFU_REL_EQ       3'd0
`define CFU_REL_NE       3'd1
`define CFU_REL_LT       3'd2
`define CFU_REL_LE       3'd3
`define CFU_REL_GT       3'd4
`define CFU_REL_GE       3'd5
// contact forms
`define CFU_FORM_LOAD    2'd0
`define CFU_FORM_AND     2'd1
`define CFU_FORM_OR      2'd2
// control word mask bits
`define CFU_MASK_SEC     0
`define CFU_MASK_YEAR    5
`define CFU_MASK_ALL     6'h3f
// fixed calendar value of the clockless model
`define CFU_FIXED_CAL    16'h0101
// year bcd threshold: 98 and 99 belong to the previous century
`define CFU_YEAR_WRAP    8'h98
`endif

// *** cfu_rel_decode.v ***
`timescale 1ns/1ps
`include "cfu_consts.vh"
module cfu_rel_decode (
  input  wire [9:0] opcode_i,    // instruction code
  output reg        is_input_o,  // input comparison code
  output reg  [2:0] rel_o,       // relation
  output reg        double_o,    // double length variant
  output reg        signed_o     // signed variant
);
  reg [9:0] off;
  reg [9:0] fam;
  reg [9:0] var_sel;
  always @* begin
    off        = 10'd0;
    fam        = 10'd0;
    var_sel    = 10'd0;
    is_input_o = 1'b0;
    rel_o      = `CFU_REL_EQ;
    if (opcode_i >= `CFU_OP_EQ_BASE && opcode_i <= `CFU_OP_GE_BASE + 10'd3) begin
      off     = opcode_i - `CFU_OP_EQ_BASE;
      fam     = off / 10'd5;
      var_sel = off % 10'd5;
      // each relation family is five codes wide with the fifth unused
      if (var_sel != 10'd4) begin
        is_input_o = 1'b1;
        rel_o      = fam[2:0];
      end
    end
    // variant order: unsigned single, unsigned double, signed single, signed double
    double_o = is_input_o & (var_sel[1:0] == `CFU_VAR_DOUBLE ||
                             var_sel[1:0] == `CFU_VAR_SDOUBLE);
    signed_o = is_input_o & var_sel[1];
  end
endmodule // cfu_rel_decode

// *** cfu_seq_model.sv ***
`timescale 1ns/1ps
module cfu_seq_model (
  input  wire        core_clk_i,    // cpu clock
  output reg         exec_o,        // strobe
  output reg  [9:0]  opcode_o,      // code
  output reg  [1:0]  form_o,        // contact form
  output reg         cond_o,        // rung condition
  output reg  [31:0] first_o,       // hi and low word
  output reg  [31:0] second_o,      // hi and low word
  output reg  [47:0] first_time_o,  // present time
  output reg  [47:0] second_time_o, // comparison time
  output reg  [5:0]  mask_o,        // control bits
  output reg         use_cal_o,     // calendar as time
  output reg         cal_wr_o,      // calendar write
  output reg  [1:0]  cal_sel_o,     // calendar word
  output reg  [15:0] cal_wdata_o    // write data
);
  initial begin
    {exec_o, opcode_o, form_o, cond_o, first_o, second_o} = 0;
    {first_time_o, second_time_o, mask_o, use_cal_o, cal_wr_o, cal_sel_o, cal_wdata_o} = 0;
  end
  task issue(input [9:0] op, input [1:0] f, input c, input [31:0] x, input [31:0] y);
    begin
      @(posedge core_clk_i);
      // high word sits in [31:16]
      {exec_o, opcode_o, form_o, cond_o, first_o, second_o} <= {1'b1, op, f, c, x, y};
      @(posedge core_clk_i);
      exec_o <= 1'b0;
    end
  endtask
  task set_time(input [47:0] p, input [47:0] q, input [5:0] m, input u);
    begin
      @(posedge core_clk_i);
      {first_time_o, second_time_o, mask_o, use_cal_o} <= {p, q, m, u};
    end
  endtask
  task wr_cal(input [1:0] s, input [15:0] d);
    begin
      @(posedge core_clk_i);
      {cal_wr_o, cal_sel_o, cal_wdata_o} <= {1'b1, s, d};
      @(posedge core_clk_i);
      cal_wr_o <= 1'b0;
    end
  endtask
endmodule // cfu_seq_model

// *** cfu_time_cmp.v ***
`timescale 1ns/1ps
`include "cfu_consts.vh"
module cfu_time_cmp (
  input  wire [47:0] first_time_i,   // present time, three words
  input  wire [47:0] second_time_i,  // comparison time, three words
  input  wire [5:0]  mask_i,         // 1 excludes field
  output reg         greater_o,      // first later than second
  output reg         less_o          // first earlier than second
);
  reg [8:0] fa;
  reg [8:0] fb;
  integer   i;
  // field i: second, minute, hour, day, month, year; byte i of the operand
  always @* begin
    greater_o = 1'b0;
    less_o    = 1'b0;
    fa        = 9'd0;
    fb        = 9'd0;
    for (i = 0; i < 6; i = i + 1) begin
      // 8-bit fields compared separately so each can be masked
      fa = {1'b0, first_time_i[i*8 +: 8]};
      fb = {1'b0, second_time_i[i*8 +: 8]};
      if (i == `CFU_MASK_YEAR) begin
        // years 98,99 rank below 00..97
        fa[8] = (first_time_i[47:40] < `CFU_YEAR_WRAP);
        fb[8] = (second_time_i[47:40] < `CFU_YEAR_WRAP);
      end
      // later iterations are more significant and override
      if (!mask_i[i] && fa != fb) begin
        greater_o = fa > fb;
        less_o    = fa < fb;
      end
    end
  end
endmodule // cfu_time_cmp

// *** testbench.sv ***
`timescale 1ns/1ps
`include "cfu_consts.vh"
module testbench;
  reg         clk;
  reg         rstn;
  wire        exec, cond, use_cal, cal_wr, ec, cv, sk, er;
  wire [9:0]  opc;
  wire [1:0]  form, sel;
  wire [31:0] a_w, b_w;
  wire [47:0] t1, t2;
  wire [5:0]  mask, flags;
  wire [15:0] wd, c0, c1, c2;
  integer     num_errors = 0;
  integer     checks = 0;
  integer     fam, v, s;
  reg  [31:0] a, b;
  reg  [2:0]  r;
  cfu_seq_model u_seq (.core_clk_i(clk), .exec_o(exec), .opcode_o(opc), .form_o(form),
    .cond_o(cond), .first_o(a_w), .second_o(b_w), .first_time_o(t1), .second_time_o(t2),
    .mask_o(mask), .use_cal_o(use_cal), .cal_wr_o(cal_wr), .cal_sel_o(sel), .cal_wdata_o(wd));
  cfu_compare_flag_unit u_dut (.core_clk_i(clk), .rstn_i(rstn), .exec_i(exec), .opcode_i(opc),
    .form_i(form), .cond_i(cond), .first_operand_i(a_w[15:0]), .first_operand_hi_i(a_w[31:16]),
    .second_operand_i(b_w[15:0]), .second_operand_hi_i(b_w[31:16]), .first_time_i(t1),
    .second_time_i(t2), .use_calendar_i(use_cal), .mask_i(mask), .cal_wr_i(cal_wr),
    .cal_sel_i(sel), .cal_wdata_i(wd), .calendar_second_minute_o(c0),
    .calendar_hour_day_o(c1), .calendar_month_year_o(c2), .exec_cond_o(ec),
    .cond_valid_o(cv), .skip_rung_o(sk), .error_flag_o(er), .greater_flag_o(flags[5]),
    .greater_equal_flag_o(flags[4]), .equal_flag_o(flags[3]), .not_equal_flag_o(flags[2]),
    .less_flag_o(flags[1]), .less_equal_flag_o(flags[0]));
  // {gt, eq, lt} of two operands under the chosen variant
  function [2:0] rel(input [31:0] x, input [31:0] y, input dbl, input sg);
    reg signed [32:0] p, q;
    begin
      p = dbl ? {sg & x[31], x} : {{17{sg & x[15]}}, x[15:0]};
      q = dbl ? {sg & y[31], y} : {{17{sg & y[15]}}, y[15:0]};
      rel = {p > q, p == q, p < q};
    end
  endfunction
  function [5:0] fl(input [2:0] k);
    fl = {k[2], k[2] | k[1], k[1], !k[1], k[0], k[0] | k[1]};
  endfunction
  function res(input integer f, input [2:0] k);
    res = f == 0 ? k[1] : f == 1 ? !k[1] : f == 2 ? k[0] : f == 3 ? !k[2] : f == 4 ? k[2] : !k[0];
  endfunction
  task check(input [8*8:1] nm, input [47:0] seen, input [47:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task run(input [9:0] op, input [1:0] f, input c, input [31:0] x, input [31:0] y);
    begin
      u_seq.issue(op, f, c, x, y);
      @(negedge clk);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial begin
    rstn = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("cal", {c2, c1, c0}, 48'h010101010101);
    // set 0 splits signed from unsigned, set 1 splits double from single
    for (s = 0; s < 2; s = s + 1)
      for (fam = 0; fam < 6; fam = fam + 1)
        for (v = 0; v < 4; v = v + 1) begin
          a = s ? 32'h0002_0005 : 32'h0001_8000;
          b = s ? 32'h0001_0005 : 32'h0001_0001;
          r = rel(a, b, v[0], v[1]);
          run(300 + 5 * fam + v, `CFU_FORM_LOAD, 1'b1, a, b);
          check("icond", ec, res(fam, r));
          check("iflags", flags, fl(r));
        end
    $display("input compare test done");
    run(`CFU_OP_LT_BASE, `CFU_FORM_AND, 1'b1, 32'd7, 32'd5);
    check("skip", {sk, ec, cv}, 3'b101);
    run(`CFU_OP_LT_BASE, `CFU_FORM_AND, 1'b0, 32'd5, 32'd7);
    check("andoff", ec, 1'b0);
    run(`CFU_OP_EQ_BASE, `CFU_FORM_OR, 1'b1, 32'd1, 32'd2);
    check("oron", {sk, ec}, 2'b01);
    run(`CFU_OP_EQ_BASE, `CFU_FORM_OR, 1'b0, 32'd3, 32'd4);
    check("oroff", ec, 1'b0);
    $display("contact form test done");
    u_seq.set_time(48'h0, 48'h0101_0102_0101, 6'h00, 1'b1);
    for (fam = 0; fam < 6; fam = fam + 1) begin
      run(341 + fam, `CFU_FORM_LOAD, 1'b1, 32'd0, 32'd0);
      check("tcond", ec, res(fam, 3'b001));
      check("tflags", flags, fl(3'b001));
    end
    u_seq.set_time(48'h0, 48'h0101_0102_0101, 6'h04, 1'b1);
    run(`CFU_OP_TEQ, `CFU_FORM_LOAD, 1'b1, 32'd0, 32'd0);
    check("tmask", ec, 1'b1);
    u_seq.set_time(48'h9801_0101_0159, 48'h0001_0101_0101, 6'h00, 1'b0);
    run(10'd343, `CFU_FORM_LOAD, 1'b1, 32'd0, 32'd0);
    check("tyear", {ec, flags}, {1'b1, fl(3'b001)});
    u_seq.set_time(48'h9801_0101_0159, 48'h0001_0101_0101, 6'h3f, 1'b0);
    run(`CFU_OP_TEQ, `CFU_FORM_AND, 1'b1, 32'd0, 32'd0);
    check("tall", {er, ec, flags}, {2'b10, fl(3'b001)});
    $display("time compare test done");
    run(`CFU_OP_CMP, `CFU_FORM_LOAD, 1'b1, 32'd3, 32'd3);
    check("cmp", {er, ec, cv, flags}, {3'b100, fl(3'b010)});
    run(`CFU_OP_PLAIN_COMPARE_DOUBLE, `CFU_FORM_LOAD, 1'b1, 32'h0001_0000, 32'h0000_ffff);
    check("plain_compare_double", {ec, flags}, {1'b0, fl(3'b100)});
    run(10'd304, `CFU_FORM_LOAD, 1'b1, 32'd5, 32'd1);
    check("unknown", {cv, flags}, {1'b0, fl(3'b100)});
    u_seq.wr_cal(2'd1, 16'h2308);
    @(negedge clk);
    check("calwr", c1, 16'h2308);
    $display("plain compare and calendar test done");
    wrap_up;
  end
endmodule // testbench
